// *** rtl/fbec_pkg.sv ***
package fbec_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 40;
	// Pulse lengths are counted in CPU cycles, quoted at this reference rate
	localparam int unsigned REF_MHZ = 20;
	localparam int unsigned UNLOCK_WAIT_US = 10;
	localparam int unsigned UNLOCK_WAIT_CYC = UNLOCK_WAIT_US * CLK_MHZ;
	localparam int unsigned VERIFY_GAP_US = 4;
	localparam int unsigned VERIFY_GAP_CYC = VERIFY_GAP_US * CLK_MHZ;
	localparam int unsigned PULSE_US_0 = 10;
	localparam int unsigned PULSE_US_1 = 100;
	localparam int unsigned PULSE_US_2 = 1000;
	localparam int unsigned PULSE_US_3 = 10000;
	localparam int unsigned PULSE_CYC_0 = PULSE_US_0 * REF_MHZ;
	localparam int unsigned PULSE_CYC_1 = PULSE_US_1 * REF_MHZ;
	localparam int unsigned PULSE_CYC_2_DEF = PULSE_US_2 * REF_MHZ;
	localparam int unsigned PULSE_CYC_3_DEF = PULSE_US_3 * REF_MHZ;

	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [15:0] CTRL_OFS = 16'h0000;
	localparam logic [3:0] ARRAY_PAGE = 4'h1;
	localparam logic [15:0] ERASED_WORD = 16'hffff;

	// ----------------------------------------
	// Control register layout
	// ----------------------------------------
	localparam int unsigned BIT_WE = 0;
	localparam int unsigned BIT_ERASE = 1;
	localparam int unsigned BIT_BUSY = 2;
	localparam int unsigned BIT_ERR = 3;
	localparam int unsigned BIT_VALID = 4;
	localparam int unsigned PLEN_LSB = 5;
	localparam int unsigned BIT_DWORD = 7;
	localparam int unsigned BANK_LSB = 8;
	localparam int unsigned MODE_LSB = 10;
	localparam int unsigned BIT_WMODE = 12;
	localparam int unsigned BIT_HOLD = 15;

	typedef struct packed {
		logic hold;
		logic [1:0] bank;
		logic dword;
		logic [1:0] plen;
		logic erase;
		logic we;
	} fbec_ctrl_t;

	localparam fbec_ctrl_t CTRL_RST = 8'h00;

	typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_WAIT = 3'b010, BUS_ACK = 3'b100} fbec_bus_t;
	typedef enum logic [3:0] {LK_STD = 4'b0001, LK_ARMED = 4'b0010, LK_WAIT = 4'b0100, LK_WRITE = 4'b1000} fbec_lock_t;
	typedef enum logic [2:0] {SQ_IDLE = 3'b001, SQ_UPD = 3'b010, SQ_PULSE = 3'b100} fbec_seq_t;
	typedef enum logic [1:0] {VM_NONE = 2'b00, VM_PROG = 2'b01, VM_ERASE = 2'b10} fbec_vmode_t;

endpackage

// *** rtl/fbec_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module fbec_timer #(
	parameter int unsigned W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	output logic run_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	if (W < 2) begin : g_bad_w
		$error("fbec_timer: W must be at least 2");
	end

	always_comb begin
		nxt_cnt = cnt_ff;
		if (load_i) begin
			nxt_cnt = count_i;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign run_o = (cnt_ff != '0);
endmodule // fbec_timer
`default_nettype wire

// *** rtl/fbec_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
module fbec_mem #(
	parameter int unsigned DW = 16,
	parameter int unsigned AW = 6
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] rd_adr_i,
	output logic [DW-1:0] rd_dat_o,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_adr_i,
	input wire logic [DW-1:0] wr_dat_i
);
	logic [DW-1:0] mem_ff [2**AW];

	if (AW < 1 || DW < 1) begin : g_bad_size
		$error("fbec_mem: AW and DW must be positive");
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (wr_en_i) begin
				mem_ff[wr_adr_i] <= wr_dat_i;
			end
			rd_dat_o <= mem_ff[rd_adr_i];
		end
	end
endmodule // fbec_mem
`default_nettype wire

// *** rtl/fbec_top.sv ***
// How it works
// - Four banks; an erase rewrites only the selected bank.
// - Writing mode needs dummy control write, address-equals-data array write, 10 us wait.
// - Control writes only select; bit 0 enables writes, bit 1 picks erase.
// - Bits 6:5 pick pulse length in cycles; code 11 is 10 ms.
// - Bits 9:8 pick the bank to erase.
// - Bit 15 keeps the array in writing mode.
// - Bit 4 reads the supply-valid input.
// - In erase mode any array write starts the erase pulse.
// - Bit 2 reads one while a pulse runs.
// - An ended erase pulse enters erase-verify read mode by itself.
// - Supply loss during a pulse sets sticky error bit 3.
// - Verify reads need two same-address reads 4 us apart.
// - Clearing bit 0 leaves verify mode; array reads normally.
// - Clearing bit 15 returns to standard mode.
// - Control register takes only full 16-bit writes.
// - Doubleword mode pairs two writes to one address, second starts programming.
// - Code 01 gives a 100 us programming pulse.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fbec_top #(
	parameter int unsigned AW = 6,
	parameter int unsigned PULSE_CYC_2 = fbec_pkg::PULSE_CYC_2_DEF,
	parameter int unsigned PULSE_CYC_3 = fbec_pkg::PULSE_CYC_3_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic supply_valid_i,
	output logic hv_pulse_o,
	output logic hv_erase_o
);
	import fbec_pkg::*;

	localparam int unsigned BW = AW - 2;
	localparam int unsigned TW = $clog2(PULSE_CYC_3 + 1);
	localparam int unsigned UW = $clog2(UNLOCK_WAIT_CYC + 1);
	localparam int unsigned GW = $clog2(VERIFY_GAP_CYC + 1);

	if (AW < 3 || AW > 9 || PULSE_CYC_0 <= 2**BW || PULSE_CYC_2 < PULSE_CYC_1
		|| PULSE_CYC_3 < PULSE_CYC_2) begin : g_bad_param
		$error("fbec_top: parameters out of range");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	fbec_bus_t bus_ff, nxt_bus;
	fbec_lock_t lk_ff, nxt_lk;
	fbec_seq_t seq_ff, nxt_seq;
	fbec_vmode_t vm_ff, nxt_vm;
	fbec_ctrl_t ctrl_ff, nxt_ctrl;
	logic err_ff, nxt_err;
	logic op_erase_ff, nxt_op_erase;
	logic [AW-1:0] upd_ff, nxt_upd, end_ff, nxt_end;
	logic [15:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
	logic pend_ff, nxt_pend;
	logic [AW-1:0] pend_adr_ff, nxt_pend_adr;
	logic vseen_ff, nxt_vseen;
	logic [AW-1:0] vadr_ff, nxt_vadr;
	logic [TW-1:0] pn_ff, nxt_pn;
	logic ack_ff, nxt_ack;
	logic [31:0] dat_ff, nxt_dat;
	logic hv_ff, nxt_hv, hve_ff, nxt_hve;

	logic pulse_load, unlock_load, gap_load;
	logic pulse_run, unlock_run, gap_run;
	logic [15:0] mem_rd;
	logic [AW-1:0] idx;
	logic acc_ctrl, acc_arr, act, full_word, busy, wmode;
	logic [TW-1:0] plen_cyc;

	assign idx = wb_adr_i[AW+1:2];
	assign acc_ctrl = (wb_adr_i[15:2] == CTRL_OFS[15:2]);
	assign acc_arr = (wb_adr_i[15:12] == ARRAY_PAGE) && (wb_adr_i[11:AW+2] == '0);
	assign act = (bus_ff == BUS_WAIT) && wb_cyc_i && wb_stb_i;
	assign full_word = (wb_sel_i[1:0] == 2'b11);
	assign busy = (seq_ff != SQ_IDLE);
	assign wmode = (lk_ff == LK_WRITE);

	always_comb begin
		case (ctrl_ff.plen)
			2'b00: plen_cyc = TW'(PULSE_CYC_0);
			2'b01: plen_cyc = TW'(PULSE_CYC_1);
			2'b10: plen_cyc = TW'(PULSE_CYC_2);
			default: plen_cyc = TW'(PULSE_CYC_3);
		endcase
	end

	fbec_timer #(.W(TW)) u_pulse (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(pulse_load),
		.count_i(plen_cyc), .run_o(pulse_run));
	fbec_timer #(.W(UW)) u_unlock (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(unlock_load),
		.count_i(UW'(UNLOCK_WAIT_CYC)), .run_o(unlock_run));
	fbec_timer #(.W(GW)) u_gap (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .load_i(gap_load),
		.count_i(GW'(VERIFY_GAP_CYC)), .run_o(gap_run));

	// Erase rewrites only words of the chosen bank
	fbec_mem #(.DW(16), .AW(AW)) u_array (.clk_i(clk_i), .ce_i(ce_i), .rd_adr_i(idx), .rd_dat_o(mem_rd),
		.wr_en_i(seq_ff == SQ_UPD), .wr_adr_i(upd_ff),
		.wr_dat_i(op_erase_ff ? ERASED_WORD : ((upd_ff == pend_adr_ff) ? lo_ff : hi_ff)));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_bus = bus_ff;
		nxt_lk = lk_ff;
		nxt_seq = seq_ff;
		nxt_vm = vm_ff;
		nxt_ctrl = ctrl_ff;
		nxt_err = err_ff;
		nxt_op_erase = op_erase_ff;
		nxt_upd = upd_ff;
		nxt_end = end_ff;
		nxt_lo = lo_ff;
		nxt_hi = hi_ff;
		nxt_pend = pend_ff;
		nxt_pend_adr = pend_adr_ff;
		nxt_vseen = vseen_ff;
		nxt_vadr = vadr_ff;
		nxt_pn = pn_ff;
		nxt_ack = 1'b0;
		nxt_dat = dat_ff;
		pulse_load = 1'b0;
		unlock_load = 1'b0;
		gap_load = 1'b0;

		// Supply loss during pulse, set wins over clear
		if (busy && !supply_valid_i) begin
			nxt_err = 1'b1;
		end

		case (seq_ff)
			SQ_UPD: begin
				if (upd_ff == end_ff) begin
					nxt_seq = SQ_PULSE;
				end else begin
					nxt_upd = upd_ff + 1'b1;
				end
			end
			SQ_PULSE: begin
				if (!pulse_run) begin
					nxt_seq = SQ_IDLE;
					nxt_vm = op_erase_ff ? VM_ERASE : VM_PROG;
				end
			end
			default: begin
			end
		endcase

		if (lk_ff == LK_WAIT && !unlock_run) begin
			nxt_lk = LK_WRITE;
		end

		case (bus_ff)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					nxt_bus = BUS_WAIT;
				end
			end
			BUS_WAIT: begin
				nxt_bus = act ? BUS_ACK : BUS_IDLE;
				nxt_ack = act;
				nxt_dat = '0;
				if (act && !wb_we_i) begin
					if (acc_ctrl) begin
						nxt_dat[15:0] = {ctrl_ff.hold, 2'b00, wmode, vm_ff, ctrl_ff.bank, ctrl_ff.dword,
							ctrl_ff.plen, supply_valid_i, err_ff, busy, ctrl_ff.erase, ctrl_ff.we};
					end else if (acc_arr && vm_ff != VM_NONE) begin
						// Second read of same word after gap
						if (vseen_ff && vadr_ff == idx) begin
							nxt_dat[15:0] = gap_run ? 16'h0000 : mem_rd;
						end else begin
							nxt_vseen = 1'b1;
							nxt_vadr = idx;
							gap_load = 1'b1;
						end
					end else if (acc_arr) begin
						nxt_dat[15:0] = mem_rd;
					end
				end else if (act && acc_ctrl && full_word) begin
					case (lk_ff)
						LK_STD, LK_ARMED: begin
							nxt_lk = LK_ARMED;
						end
						LK_WRITE: begin
							if (!busy) begin
								nxt_ctrl.we = wb_dat_i[BIT_WE];
								nxt_ctrl.erase = wb_dat_i[BIT_ERASE];
								nxt_ctrl.plen = wb_dat_i[PLEN_LSB+1:PLEN_LSB];
								nxt_ctrl.dword = wb_dat_i[BIT_DWORD];
								nxt_ctrl.bank = wb_dat_i[BANK_LSB+1:BANK_LSB];
								nxt_ctrl.hold = wb_dat_i[BIT_HOLD];
								if (wb_dat_i[BIT_ERR] && !(busy && !supply_valid_i)) begin
									nxt_err = 1'b0;
								end
								if (!wb_dat_i[BIT_WE]) begin
									nxt_vm = VM_NONE;
									nxt_pend = 1'b0;
								end
								if (!wb_dat_i[BIT_HOLD]) begin
									nxt_lk = LK_STD;
									nxt_ctrl.we = 1'b0;
									nxt_vm = VM_NONE;
									nxt_pend = 1'b0;
								end
							end
						end
						default: begin
						end
					endcase
				end else if (act && acc_ctrl) begin
					if (lk_ff == LK_ARMED) begin
						nxt_lk = LK_STD;
					end
				end else if (act && acc_arr) begin
					if (lk_ff == LK_ARMED) begin
						if (wb_dat_i[15:0] == wb_adr_i) begin
							nxt_lk = LK_WAIT;
							unlock_load = 1'b1;
						end else begin
							nxt_lk = LK_STD;
						end
					end else if (wmode && ctrl_ff.we && !busy) begin
						if (ctrl_ff.erase) begin
							// Erase start on any array write
							nxt_upd = {ctrl_ff.bank, {BW{1'b0}}};
							nxt_end = {ctrl_ff.bank, {BW{1'b1}}};
							nxt_op_erase = 1'b1;
							nxt_seq = SQ_UPD;
						end else if (ctrl_ff.dword && !(pend_ff && pend_adr_ff == idx)) begin
							nxt_pend = 1'b1;
							nxt_pend_adr = idx;
							nxt_lo = wb_dat_i[15:0];
						end else begin
							// A write with doubleword off, or the second write of a pair, starts programming
							nxt_upd = ctrl_ff.dword ? pend_adr_ff : idx;
							nxt_end = ctrl_ff.dword ? pend_adr_ff + 1'b1 : idx;
							nxt_pend_adr = ctrl_ff.dword ? pend_adr_ff : idx;
							nxt_lo = ctrl_ff.dword ? lo_ff : wb_dat_i[15:0];
							nxt_hi = wb_dat_i[15:0];
							nxt_pend = 1'b0;
							nxt_op_erase = 1'b0;
							nxt_seq = SQ_UPD;
						end
						if (nxt_seq == SQ_UPD) begin
							pulse_load = 1'b1;
							nxt_pn = plen_cyc;
							nxt_vm = VM_NONE;
							nxt_vseen = 1'b0;
						end
					end
				end
			end
			default: begin
				nxt_bus = BUS_IDLE;
			end
		endcase

		nxt_hv = (nxt_seq != SQ_IDLE);
		nxt_hve = (nxt_seq != SQ_IDLE) && nxt_op_erase;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_ff <= BUS_IDLE;
			lk_ff <= LK_STD;
			seq_ff <= SQ_IDLE;
			vm_ff <= VM_NONE;
			ctrl_ff <= CTRL_RST;
			err_ff <= 1'b0;
			op_erase_ff <= 1'b0;
			upd_ff <= '0;
			end_ff <= '0;
			lo_ff <= '0;
			hi_ff <= '0;
			pend_ff <= 1'b0;
			pend_adr_ff <= '0;
			vseen_ff <= 1'b0;
			vadr_ff <= '0;
			pn_ff <= '0;
			ack_ff <= 1'b0;
			dat_ff <= '0;
			hv_ff <= 1'b0;
			hve_ff <= 1'b0;
		end else if (ce_i) begin
			bus_ff <= nxt_bus;
			lk_ff <= nxt_lk;
			seq_ff <= nxt_seq;
			vm_ff <= nxt_vm;
			ctrl_ff <= nxt_ctrl;
			err_ff <= nxt_err;
			op_erase_ff <= nxt_op_erase;
			upd_ff <= nxt_upd;
			end_ff <= nxt_end;
			lo_ff <= nxt_lo;
			hi_ff <= nxt_hi;
			pend_ff <= nxt_pend;
			pend_adr_ff <= nxt_pend_adr;
			vseen_ff <= nxt_vseen;
			vadr_ff <= nxt_vadr;
			pn_ff <= nxt_pn;
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
			hv_ff <= nxt_hv;
			hve_ff <= nxt_hve;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign hv_pulse_o = hv_ff;
	assign hv_erase_o = hve_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [UW:0] wait_cnt_ff;
	logic [TW:0] busy_cnt_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_cnt_ff <= '0;
			busy_cnt_ff <= '0;
		end else if (ce_i) begin
			wait_cnt_ff <= (lk_ff == LK_WAIT) ? wait_cnt_ff + 1'b1 : '0;
			busy_cnt_ff <= busy ? busy_cnt_ff + 1'b1 : '0;
		end
	end

	a_no_pulse_locked: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy) |-> $past(ctrl_ff.we) && $past(lk_ff) == LK_WRITE)
		else $error("pulse started with writes disabled");
	a_start_on_array: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy) |-> $past(act && acc_arr && wb_we_i))
		else $error("pulse started without array write");
	a_unlock_wait_len: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(lk_ff) == LK_WAIT && lk_ff == LK_WRITE) |-> wait_cnt_ff > UNLOCK_WAIT_CYC)
		else $error("writing mode entered before unlock wait");
	a_pulse_len_exact: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		$fell(busy) |-> busy_cnt_ff == pn_ff + 1'b1)
		else $error("pulse length differs from selected code");
	a_erase_verify_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		($fell(busy) && op_erase_ff) |-> vm_ff == VM_ERASE)
		else $error("erase-verify mode not entered");
	a_supply_err_set: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(busy && !supply_valid_i) |=> err_ff ##1 err_ff)
		else $error("supply error not flagged");
	a_bank_only_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(seq_ff == SQ_UPD && op_erase_ff) |-> upd_ff[AW-1:BW] == ctrl_ff.bank)
		else $error("erase touched another bank");
	a_partial_ignored: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(act && acc_ctrl && wb_we_i && !full_word)
		|=> ctrl_ff == $past(ctrl_ff) && (lk_ff != LK_WAIT || $past(lk_ff) == LK_WAIT))
		else $error("partial control write took effect");
	a_hold_clear_exit: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
		(act && acc_ctrl && wb_we_i && full_word && wmode && !busy && !wb_dat_i[BIT_HOLD])
		|=> lk_ff == LK_STD && vm_ff == VM_NONE)
		else $error("writing mode kept after hold cleared");
	a_verify_gap_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(act && acc_arr && !wb_we_i && vm_ff != VM_NONE && gap_run) |=> wb_ack_o && wb_dat_o == '0)
		else $error("verify read returned data before gap");

	c_erase_done: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy) && op_erase_ff);
	c_dword_start: cover property (@(posedge clk_i) disable iff (rst_i) $rose(busy) && ctrl_ff.dword);
	c_unlocked: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wmode));
endmodule // fbec_top
`default_nettype wire

// *** tb/test_flash_bank_erase_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_flash_bank_erase_control;
	import fbec_pkg::*;

	// ----------------------------------------
	// Clock, reset and stimulus signals
	// ----------------------------------------
	localparam int unsigned P2 = 2000;
	localparam int unsigned P3 = 2400;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic supply_valid_i = 1'b1;
	logic hv_pulse_o;
	logic hv_erase_o;
	int bad_count = 0;
	int checks = 0;
	logic [32:0] rd_q[$];
	logic [16:0] pulse_q[$];
	logic [31:0] seed = 32'd89140;

	fbec_top #(.AW(6), .PULSE_CYC_2(P2), .PULSE_CYC_3(P3)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_valid_i(supply_valid_i),
		.hv_pulse_o(hv_pulse_o), .hv_erase_o(hv_erase_o));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				report_and_stop();
			end
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [31:0] q;
		wb(a, 1'b1, {16'h0000, d}, 4'hf, q);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic chk, output logic [31:0] q);
		rd_q.push_back({chk, 16'h0000, e});
		wb(a, 1'b0, 32'h0, 4'hf, q);
	endtask

	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h4;
		while (q[BIT_BUSY] !== 1'b0 && n < 3000) begin
			rd(CTRL_OFS, 16'h0, 1'b0, q);
			n++;
		end
	endtask

	// ----------------------------------------
	// Monitors: read data and pulse lengths
	// ----------------------------------------
	logic [32:0] rexp;
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
			rexp = rd_q.pop_front();
			if (rexp[32]) begin
				cmp("read data", rexp[31:0], wb_dat_o);
			end
		end
	end

	int pc = 0;
	logic er_seen = 1'b0;
	logic [16:0] pexp;
	always @(posedge clk_i) begin
		if (hv_pulse_o === 1'b1) begin
			pc++;
			er_seen = hv_erase_o;
		end else if (pc != 0) begin
			pexp = (pulse_q.size() > 0) ? pulse_q.pop_front() : 17'h0;
			cmp("pulse length", {16'h0, pexp[16:1]}, pc);
			cmp("pulse kind", {31'h0, pexp[0]}, {31'h0, er_seen});
			pc = 0;
		end
	end

	initial begin
		#(25ns * 30000);
		bad_count++;
		report_and_stop();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	logic [31:0] q;
	logic [15:0] rnd;
	logic [15:0] cw[2] = '{16'h8001, 16'h8021};
	logic [5:0] wi[2] = '{6'd4, 6'd20};
	logic [15:0] len[2] = '{16'd201, 16'd2001};
	logic [15:0] wd[2];
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		seed = xs(seed);
		rnd = seed[15:0];
		rd(CTRL_OFS, 16'h0010, 1'b1, q);
		supply_valid_i <= 1'b0;
		@(posedge clk_i);
		rd(CTRL_OFS, 16'h0000, 1'b1, q);
		supply_valid_i <= 1'b1;
		rd(16'h0008 | {rnd[7:4], 4'h0}, 16'h0000, 1'b1, q);
		wr(CTRL_OFS, 16'h8063);
		rd(CTRL_OFS, 16'h0010, 1'b1, q);
		wr(16'h1000, 16'h1000);
		repeat (UNLOCK_WAIT_CYC + 20) @(posedge clk_i);
		rd(CTRL_OFS, 16'h1010, 1'b1, q);
		wb(CTRL_OFS, 1'b1, 32'h8001, 4'h1, q);
		rd(CTRL_OFS, 16'h1010, 1'b1, q);
		wr(CTRL_OFS, 16'h8000);
		wr(16'h1010, 16'h1234);
		rd(CTRL_OFS, 16'h9010, 1'b1, q);
		wd[0] = rnd;
		wd[1] = 16'h0000;
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_OFS, cw[i]);
			pulse_q.push_back({len[i], 1'b0});
			wr(16'h1000 + {8'h0, wi[i], 2'b00}, wd[i]);
			rd(CTRL_OFS, cw[i] | 16'h1014, 1'b1, q);
			wait_idle();
			rd(CTRL_OFS, cw[i] | 16'h1410, 1'b1, q);
		end
		// Zero the whole of bank 1 in pairs before it is erased
		wr(CTRL_OFS, 16'h8081);
		for (int j = 16; j < 32; j += 2) begin
			pulse_q.push_back({16'd201, 1'b0});
			wr(16'h1000 + 16'(j * 4), 16'h0000);
			wr(16'h1000 + 16'(j * 4), 16'h0000);
			wait_idle();
		end
		pulse_q.push_back({16'd201, 1'b0});
		wr(16'h1080, ~rnd);
		wr(16'h1080, rnd);
		wait_idle();
		wr(CTRL_OFS, 16'h8163);
		pulse_q.push_back({16'(P3 + 11), 1'b1});
		wr(16'h100c, 16'h100c);
		rd(CTRL_OFS, 16'h9177, 1'b1, q);
		supply_valid_i <= 1'b0;
		@(posedge clk_i);
		supply_valid_i <= 1'b1;
		// Frozen clock enable stretches the pulse by ten cycles
		ce_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		ce_i <= 1'b1;
		wait_idle();
		rd(CTRL_OFS, 16'h997b, 1'b1, q);
		for (int j = 16; j < 32; j++) begin
			rd(16'h1000 + 16'(j * 4), 16'h0000, 1'b1, q);
			repeat (VERIFY_GAP_CYC + 10) @(posedge clk_i);
			rd(16'h1000 + 16'(j * 4), ERASED_WORD, 1'b1, q);
		end
		rd(16'h1010, 16'h0000, 1'b1, q);
		rd(16'h1010, 16'h0000, 1'b1, q);
		repeat (VERIFY_GAP_CYC + 10) @(posedge clk_i);
		rd(16'h1010, wd[0], 1'b1, q);
		wr(CTRL_OFS, 16'h8008);
		rd(16'h1010, wd[0], 1'b1, q);
		rd(16'h1080, ~rnd, 1'b1, q);
		rd(16'h1084, rnd, 1'b1, q);
		rd(CTRL_OFS, 16'h9010, 1'b1, q);
		wr(CTRL_OFS, 16'h0000);
		rd(CTRL_OFS, 16'h0010, 1'b1, q);
		repeat (5) @(posedge clk_i);
		cmp("pulse queue left", 32'h0, pulse_q.size());
		report_and_stop();
	end
endmodule // test_flash_bank_erase_control
`default_nettype wire
